// file: include/glyph_cursor_pkg.sv
package glyph_cursor_pkg;

  // Serial frame layout: read flag, 7-bit command address, data byte
  localparam int           FRAME_BITS     = 16;
  localparam int           CMD_BITS       = 8;
  localparam int           CMD_READ_BIT   = 15;
  localparam int           CMD_ADDR_HI    = 14;
  localparam int           CMD_ADDR_LO    = 8;
  localparam int           DATA_HI        = 7;
  localparam int           PTR_LOAD_BIT   = 7;

  // Command addresses
  localparam logic [6:0]   ADDR_GLYPH_STORE_PORT = 7'h05;
  localparam logic [6:0]   ADDR_CURSOR_CONTROL   = 7'h0F;

  // Font pointer values
  localparam logic [7:0]   PTR_FIRST       = 8'h80;
  localparam logic [7:0]   PTR_FINAL       = 8'hF7;
  localparam logic [7:0]   PTR_INVALID_MIN = 8'hF8;

  // Glyph slot bases
  localparam logic [7:0]   GLYPH_SLOT_FIRST = 8'h80;
  localparam logic [7:0]   GLYPH_SLOT_THIRD = 8'h8A;
  localparam logic [7:0]   GLYPH_SLOT_LAST  = 8'hF3;
  localparam int           SLOT_STRIDE      = 5;
  localparam int           SLOT_COUNT       = 24;
  localparam int           ENTRY_COUNT      = 120;
  localparam int           ENTRY_BITS       = 7;
  localparam int           INDEX_BITS       = 7;

  // Cursor register layout
  localparam int           CURSOR_BLINK_BIT = 7;
  localparam int           CURSOR_POS_HI    = 6;
  localparam int           CURSOR_NONE_LO   = 5;
  localparam logic [7:0]   CURSOR_RESET     = 8'h60;

  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_OVER} frame_state_type;

endpackage

// file: verilog/glyph_store.sv
`timescale 1ns/1ps
module glyph_store
#(
  parameter int ENTRIES = 120,
  parameter int WIDTH   = 7,
  parameter int IDX_W   = 7
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // Host write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_index,
  input  wire logic [WIDTH-1:0] wr_data,
  // Host and scan read ports
  input  wire logic [IDX_W-1:0] host_index,
  output logic      [WIDTH-1:0] host_data,
  input  wire logic [IDX_W-1:0] scan_index,
  output logic      [WIDTH-1:0] scan_data
);

  logic [WIDTH-1:0] mem_ff [ENTRIES];

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < ENTRIES; i++)
        mem_ff[i] <= '0;
    end
    else if (wr_en && (int'(wr_index) < ENTRIES))
      mem_ff[wr_index] <= wr_data;
  end

  // Out-of-range indices read as blank columns
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      host_data <= '0;
      scan_data <= '0;
    end
    else
    begin
      host_data <= (int'(host_index) < ENTRIES) ? mem_ff[host_index] : '0;
      scan_data <= (int'(scan_index) < ENTRIES) ? mem_ff[scan_index] : '0;
    end
  end

endmodule

// file: verilog/cursor_unit.sv
`timescale 1ns/1ps
module cursor_unit
  import glyph_cursor_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Register access
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] reg_value,
  // Display side
  input  wire logic       blink_first_half,
  output logic            enable,
  output logic            lit
);

  logic [7:0] cursor_ff;

  always_ff @(posedge clock)
  begin
    if (srst)
      cursor_ff <= CURSOR_RESET;
    else if (wr_en)
      cursor_ff <= wr_data;
  end

  assign reg_value = cursor_ff;
  assign enable    = ~(cursor_ff[CURSOR_POS_HI] & cursor_ff[CURSOR_NONE_LO]);

  always_ff @(posedge clock)
  begin
    if (srst)
      lit <= 1'b0;
    else
      lit <= enable && (!cursor_ff[CURSOR_BLINK_BIT] || blink_first_half);
  end

endmodule

// file: verilog/glyph_cursor_regs.sv
`timescale 1ns/1ps
// Function
// - Font data write stores 7 bits, pointer advances
// - Write with top bit loads pointer only
// - Font read returns entry, MSB zero, advances
// - Pointer auto-increments within 0x80 to 0xF6
// - Access at 0xF7 locks data until reload
// - Pointer load 0xF8-0xFF becomes 0x80
// - Slot n starts at 0x80 plus 5n
// - Cursor holds blink bit and 7-bit position
// - Blink clear lights steadily, else first half
module glyph_cursor_regs
(
  // Clock and reset
  input  wire logic                                 CLOCK,
  input  wire logic                                 SRST,
  // Serial register pins
  input  wire logic                                 CS_N,
  input  wire logic                                 SCLK,
  input  wire logic                                 DIN,
  output logic                                      DOUT,
  output logic                                      DOUT_OE,
  // Scan read of the glyph store
  input  wire logic [4:0]                           SCAN_SLOT,
  input  wire logic [2:0]                           SCAN_COLUMN,
  output logic      [glyph_cursor_pkg::ENTRY_BITS-1:0] SCAN_DATA,
  // Cursor to the scan logic
  input  wire logic                                 BLINK_FIRST_HALF,
  output logic      [6:0]                           CURSOR_POSITION,
  output logic                                      CURSOR_ENABLE,
  output logic                                      CURSOR_LIT,
  // Pointer status
  output logic      [7:0]                           FONT_POINTER,
  output logic                                      FONT_LOCKED
);
  import glyph_cursor_pkg::*;

  logic [2:0]                cs_sync_ff;
  logic [2:0]                sclk_sync_ff;
  logic [1:0]                din_sync_ff;
  logic                      cs_low;
  logic                      cs_rise;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      din_s;
  frame_state_type           state_ff;
  logic [4:0]                bit_cnt_ff;
  logic [FRAME_BITS-1:0]     in_sr_ff;
  logic [7:0]                out_sr_ff;
  logic                      dout_ff;
  logic [7:0]                ptr_ff;
  logic                      done_ff;
  logic                      frame_ok;
  logic                      cmd_read;
  logic [6:0]                cmd_addr;
  logic [7:0]                cmd_data;
  logic                      glyph_cmd;
  logic                      ptr_load;
  logic                      glyph_wr_req;
  logic                      glyph_rd_req;
  logic                      data_access;
  logic                      cursor_wr;
  logic                      addr_phase_end;
  logic [CMD_BITS-1:0]       cmd_byte;
  logic [7:0]                read_byte;
  logic [INDEX_BITS-1:0]     ptr_index;
  logic [INDEX_BITS-1:0]     scan_index;
  logic [ENTRY_BITS-1:0]     host_entry;
  logic [7:0]                cursor_value;
  logic [7:0]                nxt_ptr;

  // Pin synchronisers; stage 0 feeds stage 1 only, stage 2 is for edges
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cs_sync_ff   <= 3'h7;
      sclk_sync_ff <= 3'h0;
      din_sync_ff  <= 2'h0;
    end
    else
    begin
      cs_sync_ff   <= {cs_sync_ff[1:0], CS_N};
      sclk_sync_ff <= {sclk_sync_ff[1:0], SCLK};
      din_sync_ff  <= {din_sync_ff[0], DIN};
    end
  end

  assign cs_low    = ~cs_sync_ff[1];
  assign cs_rise   = cs_sync_ff[1] & ~cs_sync_ff[2];
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign din_s     = din_sync_ff[1];

  // Frame sequencing; more than sixteen clocks voids the frame
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      state_ff <= FR_IDLE;
    else
    begin
      unique case (state_ff)
        FR_IDLE:
          if (cs_low)
            state_ff <= FR_SHIFT;
        FR_SHIFT:
          if (cs_rise)
            state_ff <= FR_IDLE;
          else if (sclk_rise && (bit_cnt_ff == 5'(FRAME_BITS)))
            state_ff <= FR_OVER;
        FR_OVER:
          if (cs_rise)
            state_ff <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST || (state_ff == FR_IDLE))
      bit_cnt_ff <= 5'h00;
    else if ((state_ff == FR_SHIFT) && sclk_rise && (bit_cnt_ff != 5'(FRAME_BITS)))
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      in_sr_ff <= '0;
    else if ((state_ff == FR_SHIFT) && sclk_rise)
      in_sr_ff <= {in_sr_ff[FRAME_BITS-2:0], din_s};
  end

  // Command decode; everything takes effect as chip select rises
  assign frame_ok     = (state_ff == FR_SHIFT) && cs_rise
                        && (bit_cnt_ff == 5'(FRAME_BITS));
  assign cmd_read     = in_sr_ff[CMD_READ_BIT];
  assign cmd_addr     = in_sr_ff[CMD_ADDR_HI:CMD_ADDR_LO];
  assign cmd_data     = in_sr_ff[DATA_HI:0];
  assign glyph_cmd    = frame_ok && (cmd_addr == ADDR_GLYPH_STORE_PORT);
  assign ptr_load     = glyph_cmd && !cmd_read && cmd_data[PTR_LOAD_BIT];
  assign glyph_wr_req = glyph_cmd && !cmd_read && !cmd_data[PTR_LOAD_BIT];
  assign glyph_rd_req = glyph_cmd && cmd_read;
  assign data_access  = (glyph_wr_req || glyph_rd_req) && !done_ff;
  assign cursor_wr    = frame_ok && !cmd_read && (cmd_addr == ADDR_CURSOR_CONTROL);

  // Read data is chosen once the command byte is complete
  assign addr_phase_end = (state_ff == FR_SHIFT) && sclk_rise && (bit_cnt_ff == 5'(CMD_BITS - 1));
  assign cmd_byte       = {in_sr_ff[CMD_BITS-2:0], din_s};

  always_comb
  begin
    read_byte = 8'h00;
    if (cmd_byte[CMD_BITS-1])
    begin
      if ((cmd_byte[6:0] == ADDR_GLYPH_STORE_PORT) && !done_ff)
        read_byte = {1'b0, host_entry};
      else if (cmd_byte[6:0] == ADDR_CURSOR_CONTROL)
        read_byte = cursor_value;
    end
  end

  // Data bits leave on falling clock edges during the second byte
  always_ff @(posedge CLOCK)
  begin
    if (SRST || (state_ff == FR_IDLE))
    begin
      out_sr_ff <= 8'h00;
      dout_ff   <= 1'b0;
    end
    else if (addr_phase_end)
      out_sr_ff <= read_byte;
    else if ((state_ff == FR_SHIFT) && sclk_fall && (bit_cnt_ff >= 5'(CMD_BITS)))
    begin
      dout_ff   <= out_sr_ff[7];
      out_sr_ff <= {out_sr_ff[6:0], 1'b0};
    end
  end

  assign DOUT    = dout_ff;
  assign DOUT_OE = (state_ff != FR_IDLE);

  // Font pointer: load, or step after a data access
  always_comb
  begin
    nxt_ptr = ptr_ff;
    if (ptr_load)
      nxt_ptr = (cmd_data >= PTR_INVALID_MIN) ? PTR_FIRST : cmd_data;
    else if (data_access && (ptr_ff != PTR_FINAL))
      nxt_ptr = ptr_ff + 8'h01;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      ptr_ff <= GLYPH_SLOT_FIRST;
    else
      ptr_ff <= nxt_ptr;
  end

  // Lock stays until the host reloads the pointer
  always_ff @(posedge CLOCK)
  begin
    if (SRST || ptr_load)
      done_ff <= 1'b0;
    else if (data_access && (ptr_ff == PTR_FINAL))
      done_ff <= 1'b1;
  end

  assign FONT_POINTER = ptr_ff;
  assign FONT_LOCKED  = done_ff;
  assign ptr_index    = INDEX_BITS'(ptr_ff - PTR_FIRST);
  // Slot base is first slot plus five entries per slot
  assign scan_index   = INDEX_BITS'(int'(SCAN_SLOT) * SLOT_STRIDE + int'(SCAN_COLUMN));

  glyph_store
  #(
    .ENTRIES (ENTRY_COUNT),
    .WIDTH   (ENTRY_BITS),
    .IDX_W   (INDEX_BITS)
  )
  u_store
  (
    .clock      (CLOCK),
    .srst       (SRST),
    .wr_en      (glyph_wr_req && !done_ff),
    .wr_index   (ptr_index),
    .wr_data    (cmd_data[ENTRY_BITS-1:0]),
    .host_index (ptr_index),
    .host_data  (host_entry),
    .scan_index (scan_index),
    .scan_data  (SCAN_DATA)
  );

  cursor_unit u_cursor
  (
    .clock            (CLOCK),
    .srst             (SRST),
    .wr_en            (cursor_wr),
    .wr_data          (cmd_data),
    .reg_value        (cursor_value),
    .blink_first_half (BLINK_FIRST_HALF),
    .enable           (CURSOR_ENABLE),
    .lit              (CURSOR_LIT)
  );

  assign CURSOR_POSITION = cursor_value[CURSOR_POS_HI:0];

  // Checks
  a_ptr_reset_base: assert property (@(posedge CLOCK)
    SRST |=> (ptr_ff == GLYPH_SLOT_FIRST) && !done_ff)
    else $error("pointer not at first slot after reset");

  a_ptr_load_valid: assert property (@(posedge CLOCK) disable iff (SRST)
    (ptr_load && (cmd_data < PTR_INVALID_MIN))
    |=> (ptr_ff == $past(cmd_data)) && !done_ff)
    else $error("valid pointer load not taken");

  a_ptr_load_invalid: assert property (@(posedge CLOCK) disable iff (SRST)
    (ptr_load && (cmd_data >= PTR_INVALID_MIN)) |=> (ptr_ff == PTR_FIRST))
    else $error("invalid pointer load not forced to first entry");

  a_load_no_store: assert property (@(posedge CLOCK) disable iff (SRST)
    ptr_load |-> !u_store.wr_en
    ##1 (u_store.mem_ff[$past(ptr_index)] == $past(u_store.mem_ff[ptr_index])))
    else $error("pointer load changed an entry");

  a_write_store_step: assert property (@(posedge CLOCK) disable iff (SRST)
    (glyph_wr_req && !done_ff && (ptr_ff != PTR_FINAL))
    |-> u_store.wr_en ##1 (ptr_ff == $past(ptr_ff) + 8'h01)
        && (u_store.mem_ff[$past(ptr_index)] == $past(cmd_data[ENTRY_BITS-1:0])))
    else $error("font write did not store and advance");

  a_read_step: assert property (@(posedge CLOCK) disable iff (SRST)
    (glyph_rd_req && !done_ff && (ptr_ff != PTR_FINAL))
    |=> (ptr_ff == $past(ptr_ff) + 8'h01))
    else $error("font read did not advance pointer");

  a_read_msb_clear: assert property (@(posedge CLOCK) disable iff (SRST)
    (addr_phase_end && cmd_byte[CMD_BITS-1] && (cmd_byte[6:0] == ADDR_GLYPH_STORE_PORT))
    |=> (out_sr_ff[7] == 1'b0))
    else $error("font read MSB not clear");

  a_ptr_in_range: assert property (@(posedge CLOCK) disable iff (SRST)
    (ptr_ff >= PTR_FIRST) && (ptr_ff <= PTR_FINAL))
    else $error("pointer left its legal range");

  a_final_locks: assert property (@(posedge CLOCK) disable iff (SRST)
    (data_access && (ptr_ff == PTR_FINAL)) |=> done_ff && (ptr_ff == PTR_FINAL))
    else $error("access at final entry did not lock");

  a_locked_ignores: assert property (@(posedge CLOCK) disable iff (SRST)
    (done_ff && (glyph_wr_req || glyph_rd_req))
    |-> !u_store.wr_en ##1 done_ff && $stable(ptr_ff))
    else $error("locked store accepted a data access");

  a_cursor_lit: assert property (@(posedge CLOCK) disable iff (SRST)
    ##1 (CURSOR_LIT == ($past(CURSOR_ENABLE)
         && (!$past(cursor_value[CURSOR_BLINK_BIT]) || $past(BLINK_FIRST_HALF)))))
    else $error("cursor lit does not follow blink bit");

  a_cursor_none: assert property (@(posedge CLOCK) disable iff (SRST)
    (cursor_value[CURSOR_POS_HI] && cursor_value[CURSOR_NONE_LO]) [*2] |-> !CURSOR_LIT)
    else $error("cursor lit with no-cursor position");

endmodule

// file: bench/host_serial_model.sv
`timescale 1ns/1ps
module host_serial_model
(
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Phases stay above 3 clock periods so the pin synchronisers see every edge
  task automatic frame(input logic [15:0] word, input int half, input int bits,
                       output logic [7:0] rd);
    rd = 8'h00;
    gap(1);
    cs_n = 1'b0;
    for (int i = 0; i < bits; i++)
    begin
      din = word[15 - (i % 16)];
      gap(half);
      if (i >= 8 && i < 16)
        rd[15 - i] = dout;
      sclk = 1'b1;
      gap(half);
      sclk = 1'b0;
    end
    gap(half);
    cs_n = 1'b1;
    // A released data line shows the inverse, never a stale bit
    din = ~din;
    gap(8);
  endtask
endmodule

// file: bench/glyph_cursor_regs_tb.sv
`timescale 1ns/1ps
module glyph_cursor_regs_tb;
  import glyph_cursor_pkg::*;
  logic       clock;
  logic       srst;
  logic       cs_n;
  logic       sclk;
  logic       din;
  logic       dout;
  logic       dout_oe;
  logic       bfh;
  logic       cur_en;
  logic       cur_lit;
  logic       locked;
  logic [4:0] slot;
  logic [2:0] col;
  logic [6:0] scan;
  logic [6:0] cur_pos;
  logic [7:0] ptr;
  logic [7:0] rd;
  logic [6:0] font [0:ENTRY_COUNT-1];
  int         fails;
  int         tests_run;

  glyph_cursor_regs i_dut (
    .CLOCK(clock), .SRST(srst), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout),
    .DOUT_OE(dout_oe), .SCAN_SLOT(slot), .SCAN_COLUMN(col), .SCAN_DATA(scan),
    .BLINK_FIRST_HALF(bfh), .CURSOR_POSITION(cur_pos), .CURSOR_ENABLE(cur_en),
    .CURSOR_LIT(cur_lit), .FONT_POINTER(ptr), .FONT_LOCKED(locked)
  );

  host_serial_model i_host (
    .clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic exp_lit(input logic [7:0] c, input logic b);
    return ~(c[6] & c[5]) & (~c[7] | b);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.frame({1'b0, a, d}, 4 + $urandom % 3, 16, rd);
  endtask

  task automatic rdr(input logic [6:0] a);
    i_host.frame({1'b1, a, 8'h00}, 4 + $urandom % 3, 16, rd);
  endtask

  task automatic peek(input int idx);
    slot = 5'(idx / 5);
    col  = 3'(idx % 5);
    tick(2);
    check({1'b0, scan}, {1'b0, font[idx]});
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    fails++;
    results();
  end

  initial
  begin
    logic [7:0] c;
    logic [7:0] p;
    logic [7:0] corner [4];
    void'($urandom(41194));
    corner = '{8'h00, 8'h5F, 8'hDF, 8'h60};
    srst = 1'b1;
    slot = 5'h00;
    col  = 3'h0;
    bfh  = 1'b0;
    fails = 0;
    tests_run = 0;
    foreach (font[i]) font[i] = 7'h00;
    tick(10);
    srst = 1'b0;
    tick(2);
    check(ptr, PTR_FIRST);
    check({7'h00, locked}, 8'h00);
    check({7'h00, cur_en}, 8'h00);
    check({7'h00, dout_oe}, 8'h00);
    $display("test reset done");

    wr(ADDR_GLYPH_STORE_PORT, GLYPH_SLOT_THIRD);
    check(ptr, 8'h8A);
    foreach (corner[k])
    begin
      font[10 + k] = 7'(8'h42 + 8'(k * 15));
      wr(ADDR_GLYPH_STORE_PORT, {1'b0, font[10 + k]});
      check(ptr, 8'(8'h8B + k));
    end
    wr(ADDR_GLYPH_STORE_PORT, 8'h46);
    font[14] = 7'h46;
    for (int i = 10; i < 15; i++) peek(i);
    wr(ADDR_GLYPH_STORE_PORT, GLYPH_SLOT_THIRD);
    for (int i = 10; i < 15; i++)
    begin
      rdr(7'h05);
      check(rd, {1'b0, font[i]});
    end
    check(ptr, 8'h8F);
    $display("test slot fill done");

    for (int v = 8'hF8; v <= 8'hFF; v++)
    begin
      wr(ADDR_GLYPH_STORE_PORT, 8'h8A);
      wr(ADDR_GLYPH_STORE_PORT, 8'(v));
      check(ptr, PTR_FIRST);
    end
    peek(10);
    $display("test invalid load done");

    wr(ADDR_GLYPH_STORE_PORT, GLYPH_SLOT_LAST);
    for (int k = 0; k < 5; k++)
    begin
      font[115 + k] = 7'($urandom);
      wr(ADDR_GLYPH_STORE_PORT, {1'b0, font[115 + k]});
      check(ptr, (k < 4) ? 8'(8'hF4 + k) : PTR_FINAL);
      check({7'h00, locked}, {7'h00, k == 4});
    end
    wr(ADDR_GLYPH_STORE_PORT, {1'b0, ~font[119]});
    peek(119);
    rdr(7'h05);
    check(rd, 8'h00);
    check(ptr, PTR_FINAL);
    wr(ADDR_GLYPH_STORE_PORT, PTR_FINAL);
    check({7'h00, locked}, 8'h00);
    rdr(7'h05);
    check(rd, {1'b0, font[119]});
    check({7'h00, locked}, 8'h01);
    $display("test pointer end done");

    // Reset in mid-run, with the pointer parked at the end and locked
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    foreach (font[i]) font[i] = 7'h00;
    tick(2);
    check(ptr, PTR_FIRST);
    check({7'h00, locked}, 8'h00);
    peek(119);
    $display("test mid-run reset done");

    wr(ADDR_GLYPH_STORE_PORT, 8'h8A);
    i_host.frame(16'h0599, 5, 15, rd);
    i_host.frame(16'h0599, 5, 17, rd);
    check(ptr, 8'h8A);
    $display("test short and long frames done");

    repeat (20)
    begin
      p = 8'h80 + 8'($urandom % 119);
      font[p - 8'h80] = 7'($urandom);
      wr(ADDR_GLYPH_STORE_PORT, p);
      wr(ADDR_GLYPH_STORE_PORT, {1'b0, font[p - 8'h80]});
      check(ptr, p + 8'h01);
      wr(ADDR_GLYPH_STORE_PORT, p);
      rdr(7'h05);
      check(rd, {1'b0, font[p - 8'h80]});
      peek(int'(p - 8'h80));
    end
    $display("test random font done");

    for (int n = 0; n < 12; n++)
    begin
      c = (n < 4) ? corner[n] : 8'($urandom);
      wr(ADDR_CURSOR_CONTROL, c);
      check({1'b0, cur_pos}, {1'b0, c[6:0]});
      check({7'h00, cur_en}, {7'h00, ~(c[6] & c[5])});
      rdr(7'h0F);
      check(rd, c);
      for (int b = 0; b < 2; b++)
      begin
        bfh = b[0];
        tick(3);
        check({7'h00, cur_lit}, {7'h00, exp_lit(c, b[0])});
      end
    end
    $display("test cursor done");
    results();
  end
endmodule
